// ### rtl/slsc_pkg.sv
package slsc_pkg;
  // ==========================================================
  // clocking
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int RC_HZ      = 256_000;
  localparam int RC_DIV     = SYS_CLK_HZ / RC_HZ;
  localparam int RC_CNT_W   = 9;
  localparam int PRE_W      = 3;
  localparam int DIV_W      = 7;
  localparam int TB_W       = 8;
  localparam int WDT_W      = 2;
  localparam int TONE_HI_BIT = 2;
  localparam int TONE_LO_BIT = 3;
  localparam logic [DIV_W-1:0] LCD_DIV_END = 7'h7f;
  // ==========================================================
  // pins, in synchroniser order
  localparam int P_CS   = 0;
  localparam int P_WR   = 1;
  localparam int P_RD   = 2;
  localparam int P_DAT  = 3;
  localparam int P_OSC  = 4;
  localparam int NPIN   = 5;
  localparam logic [NPIN-1:0] PIN_IDLE = 5'h0f;
  // ==========================================================
  // serial framing
  localparam int ID_W   = 3;
  localparam int ADDR_W = 6;
  localparam int CMD_W  = 9;
  localparam int WORD_W = 4;
  localparam int RAM_WORDS = 32;
  localparam int RAM_AW = 5;
  localparam logic [ID_W-1:0] ID_READ  = 3'h6;
  localparam logic [ID_W-1:0] ID_WRITE = 3'h5;
  localparam logic [ID_W-1:0] ID_CMD   = 3'h4;
  // ==========================================================
  // command decode, on code bits 8..1
  localparam logic [3:0] GRP_SYS  = 4'h0;
  localparam logic [3:0] GRP_SRC  = 4'h1;
  localparam logic [3:0] GRP_BIAS = 4'h2;
  localparam logic [3:0] OP_HALT   = 4'h0;
  localparam logic [3:0] OP_RUN    = 4'h1;
  localparam logic [3:0] OP_LCDOFF = 4'h2;
  localparam logic [3:0] OP_LCDON  = 4'h3;
  localparam logic [3:0] OP_TBDIS  = 4'h4;
  localparam logic [3:0] OP_WDDIS  = 4'h5;
  localparam logic [3:0] OP_TBEN   = 4'h6;
  localparam logic [3:0] OP_WDEN   = 4'h7;
  localparam logic [3:0] OP_TOFF   = 4'h8;
  localparam logic [3:0] OP_TON    = 4'h9;
  localparam logic [1:0] OP_CLR    = 2'h3;
  localparam logic [2:0] G3_TONE4  = 3'h2;
  localparam logic [2:0] G3_TONE2  = 3'h3;
  localparam logic [2:0] G3_ALERT  = 3'h4;
  localparam logic [2:0] G3_RATE   = 3'h5;
  localparam logic [7:0] OP_TEST   = 8'he0;
  localparam logic [7:0] OP_NORMAL = 8'he3;
  localparam logic [1:0] COM_BAD   = 2'h3;
  // ==========================================================
  // power-on values
  localparam logic [2:0] RATE_DEF    = 3'h7;
  localparam logic [1:0] COMMONS_DEF = 2'h0;

  typedef enum logic [1:0] {SRC_RC, SRC_XTAL, SRC_EXT} slsc_src_t;
  typedef enum logic [1:0] {ST_ID, ST_CMD, ST_ADDR, ST_DATA} slsc_state_t;

  // time-base step gate: rate code r gives 32k / 2^(7-r)
  function automatic logic slsc_tb_gate(input logic [DIV_W-1:0] d,
                                        input logic [2:0] r);
    logic [DIV_W-1:0] m;
    m = DIV_W'(7'h7f >> r);
    return (d & m) == m;
  endfunction : slsc_tb_gate
endpackage : slsc_pkg

// ### rtl/slsc_timebase.sv
`timescale 1ns/100ps
module slsc_timebase
  import slsc_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  input  wire logic step_in,
  input  wire logic run_in,
  input  wire logic clr_tb_in,
  input  wire logic watchdog_clear_cmd_in,
  output logic      tb_level_out,
  output logic      wdt_flag_out
);
  logic [TB_W-1:0]  tb_r,   tb_nxt;
  logic [WDT_W-1:0] wdt_r,  wdt_nxt;
  logic             flag_r, flag_nxt;
  logic             set_flag;

  always_comb begin
    tb_nxt   = tb_r;
    wdt_nxt  = wdt_r;
    flag_nxt = flag_r;
    set_flag = run_in && step_in && (&tb_r) && (&wdt_r);
    if (run_in && step_in) begin
      tb_nxt = tb_r + 1'b1;
      if (&tb_r) begin
        wdt_nxt = wdt_r + 1'b1;
      end
    end
    if (clr_tb_in || watchdog_clear_cmd_in) begin
      tb_nxt = '0;
    end
    if (watchdog_clear_cmd_in) begin
      wdt_nxt  = '0;
      flag_nxt = 1'b0;
    end
    // a timeout landing on the clear cycle still sets the flag
    if (set_flag) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tb_r   <= '0;
      wdt_r  <= '0;
      flag_r <= 1'b0;
    end else begin
      tb_r   <= tb_nxt;
      wdt_r  <= wdt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign tb_level_out = tb_r[TB_W-1];
  assign wdt_flag_out = flag_r;

  a_wdt_overflow: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    $rose(flag_r) |-> ($past(wdt_r) == '1 && $past(tb_r) == '1))
    else $error("watchdog flag set without full count");
endmodule : slsc_timebase

// ### rtl/slsc_top.sv
`timescale 1ns/100ps
module slsc_top
  import slsc_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             cs_n_in,
  input  wire logic             wr_n_in,
  input  wire logic             rd_n_in,
  input  wire logic             data_in,
  input  wire logic             osc_input_pin_in,
  output logic                  data_out,
  output logic                  data_oe_out,
  output logic                  alert_n_out,
  output logic                  alert_oe_out,
  output logic                  buzzer_pos_out,
  output logic                  buzzer_neg_out,
  output logic                  bias_on_out,
  output logic                  bias_third_out,
  output logic [1:0]            commons_out,
  output logic                  lcd_clk_out,
  output logic                  test_mode_out,
  output logic [RAM_WORDS*WORD_W-1:0] seg_ram_out
);
  // ==========================================================
  // pin synchronisers
  logic [NPIN-1:0] s1_r, s2_r, s3_r, filt_r, prev_r, filt_nxt;
  logic            wr_rise, rd_fall, cs_hi, osc_edge;

  always_comb begin
    // a pin counts as changed only once stages two and three agree
    filt_nxt = ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    wr_rise  = filt_r[P_WR] & ~prev_r[P_WR];
    rd_fall  = ~filt_r[P_RD] & prev_r[P_RD];
    cs_hi    = filt_r[P_CS];
    osc_edge = filt_r[P_OSC] & ~prev_r[P_OSC];
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_r   <= PIN_IDLE;
      s2_r   <= PIN_IDLE;
      s3_r   <= PIN_IDLE;
      filt_r <= PIN_IDLE;
      prev_r <= PIN_IDLE;
    end else begin
      s1_r   <= {osc_input_pin_in, data_in, rd_n_in, wr_n_in, cs_n_in};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  // ==========================================================
  // configuration state
  slsc_src_t  src_r, src_nxt;
  logic       osc_run_r, osc_run_nxt, bias_r, bias_nxt;
  logic       tone_on_r, tone_on_nxt, tone_hi_r, tone_hi_nxt;
  logic       tb_run_r, tb_run_nxt, tb_sel_r, tb_sel_nxt;
  logic       alert_en_r, alert_en_nxt, third_r, third_nxt;
  logic       test_r, test_nxt;
  logic [1:0] com_r, com_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic       clr_tb, watchdog_clear_cmd, sys_on;

  // ==========================================================
  // serial interface state
  slsc_state_t       st_r, st_nxt;
  logic [ID_W-1:0]   mode_r, mode_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [CMD_W-1:0]  sh_r, sh_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [1:0]        wbit_r, wbit_nxt, rbit_r, rbit_nxt;
  logic [WORD_W-1:0] word_r, word_nxt, wdata;
  logic              dout_r, dout_nxt, doe_r, doe_nxt;
  logic              ram_we;
  logic [CMD_W-1:0]  cmd;
  logic              cmd_go;
  logic [WORD_W-1:0] ram_r [RAM_WORDS];
  logic [RAM_AW-1:0] ram_a;

  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    cnt_nxt  = cnt_r;
    sh_nxt   = sh_r;
    addr_nxt = addr_r;
    wbit_nxt = wbit_r;
    rbit_nxt = rbit_r;
    word_nxt = word_r;
    dout_nxt = dout_r;
    doe_nxt  = doe_r;
    ram_we   = 1'b0;
    cmd_go   = 1'b0;
    ram_a    = addr_r[RAM_AW-1:0];
    cmd      = {sh_r[CMD_W-2:0], filt_r[P_DAT]};
    wdata    = word_r;
    wdata[wbit_r] = filt_r[P_DAT];
    if (cs_hi) begin
      st_nxt  = ST_ID;
      cnt_nxt = '0;
      doe_nxt = 1'b0;
    end else if (wr_rise) begin
      sh_nxt  = cmd;
      cnt_nxt = cnt_r + 1'b1;
      case (st_r)
        ST_ID: begin
          if (cnt_r == 4'(ID_W - 1)) begin
            cnt_nxt  = '0;
            mode_nxt = cmd[ID_W-1:0];
            if (cmd[ID_W-1:0] == ID_CMD) begin
              st_nxt = ST_CMD;
            end else if (cmd[ID_W-1:0] == ID_READ ||
                         cmd[ID_W-1:0] == ID_WRITE) begin
              st_nxt = ST_ADDR;
            end
          end
        end
        ST_CMD: begin
          // stays in command state, so later commands skip the ID
          if (cnt_r == 4'(CMD_W - 1)) begin
            cnt_nxt = '0;
            cmd_go  = 1'b1;
          end
        end
        ST_ADDR: begin
          if (cnt_r == 4'(ADDR_W - 1)) begin
            addr_nxt = cmd[ADDR_W-1:0];
            st_nxt   = ST_DATA;
            wbit_nxt = '0;
            rbit_nxt = '0;
          end
        end
        ST_DATA: begin
          if (mode_r == ID_WRITE) begin
            doe_nxt  = 1'b0;
            word_nxt = wdata;
            wbit_nxt = wbit_r + 1'b1;
            if (wbit_r == 2'(WORD_W - 1)) begin
              ram_we   = 1'b1;
              addr_nxt = addr_r + 1'b1;
              rbit_nxt = '0;
            end
          end
        end
        default: st_nxt = ST_ID;
      endcase
    end else if (rd_fall && st_r == ST_DATA) begin
      dout_nxt = ram_r[ram_a][rbit_r];
      doe_nxt  = 1'b1;
      rbit_nxt = rbit_r + 1'b1;
      if (mode_r == ID_READ && rbit_r == 2'(WORD_W - 1)) begin
        addr_nxt = addr_r + 1'b1;
      end
    end else if (!filt_r[P_WR]) begin
      // let go of the pin once a write strobe starts, so read-modify-write
      // hands the line back before its first data bit is taken
      doe_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r   <= ST_ID;
      mode_r <= '0;
      cnt_r  <= '0;
      sh_r   <= '0;
      addr_r <= '0;
      wbit_r <= '0;
      rbit_r <= '0;
      word_r <= '0;
      dout_r <= 1'b0;
      doe_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      sh_r   <= sh_nxt;
      addr_r <= addr_nxt;
      wbit_r <= wbit_nxt;
      rbit_r <= rbit_nxt;
      word_r <= word_nxt;
      dout_r <= dout_nxt;
      doe_r  <= doe_nxt;
    end
  end

  // display memory has no reset: contents are undefined at power-on
  always_ff @(posedge sys_clk_in) begin
    if (ram_we) begin
      ram_r[ram_a] <= wdata;
    end
  end

  for (genvar g = 0; g < RAM_WORDS; g++) begin : g_seg
    assign seg_ram_out[g*WORD_W +: WORD_W] = ram_r[g];
  end

  // ==========================================================
  // command execution
  always_comb begin
    src_nxt      = src_r;
    osc_run_nxt  = osc_run_r;
    bias_nxt     = bias_r;
    tone_on_nxt  = tone_on_r;
    tone_hi_nxt  = tone_hi_r;
    tb_run_nxt   = tb_run_r;
    tb_sel_nxt   = tb_sel_r;
    alert_en_nxt = alert_en_r;
    third_nxt    = third_r;
    com_nxt      = com_r;
    rate_nxt     = rate_r;
    test_nxt     = test_r;
    clr_tb       = 1'b0;
    watchdog_clear_cmd      = 1'b0;
    if (cmd_go) begin
      if (cmd[8:5] == GRP_SYS) begin
        case (cmd[4:1])
          OP_HALT: begin
            if (src_r != SRC_EXT) begin
              osc_run_nxt = 1'b0;
              bias_nxt    = 1'b0;
            end
          end
          OP_RUN:    osc_run_nxt = 1'b1;
          OP_LCDOFF: bias_nxt    = 1'b0;
          OP_LCDON:  bias_nxt    = 1'b1;
          OP_TBDIS:  tb_run_nxt  = 1'b0;
          OP_WDDIS:  tb_run_nxt  = 1'b0;
          OP_TBEN: begin
            tb_run_nxt = 1'b1;
            tb_sel_nxt = 1'b1;
          end
          OP_WDEN: begin
            tb_run_nxt = 1'b1;
            tb_sel_nxt = 1'b0;
          end
          OP_TOFF:   tone_on_nxt = 1'b0;
          OP_TON:    tone_on_nxt = 1'b1;
          default: begin
            clr_tb  = (cmd[4:3] == OP_CLR);
            watchdog_clear_cmd = (cmd[4:3] == OP_CLR) && cmd[2];
          end
        endcase
      end else if (cmd[8:5] == GRP_SRC) begin
        case (cmd[4:3])
          2'h1:    src_nxt = SRC_XTAL;
          2'h2:    src_nxt = SRC_RC;
          2'h3:    src_nxt = SRC_EXT;
          default: src_nxt = src_r;
        endcase
      end else if (cmd[8:5] == GRP_BIAS) begin
        third_nxt = cmd[1];
        if (cmd[4:3] != COM_BAD) begin
          com_nxt = cmd[4:3];
        end
      end else if (cmd[8:6] == G3_TONE4) begin
        tone_hi_nxt = 1'b1;
      end else if (cmd[8:6] == G3_TONE2) begin
        tone_hi_nxt = 1'b0;
      end else if (cmd[8:6] == G3_ALERT) begin
        alert_en_nxt = cmd[4];
      end else if (cmd[8:6] == G3_RATE) begin
        rate_nxt = cmd[3:1];
      end else if (cmd[8:1] == OP_TEST) begin
        test_nxt = 1'b1;
      end else if (cmd[8:1] == OP_NORMAL) begin
        test_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      src_r      <= SRC_RC;
      osc_run_r  <= 1'b0;
      bias_r     <= 1'b0;
      tone_on_r  <= 1'b0;
      tone_hi_r  <= 1'b1;
      tb_run_r   <= 1'b0;
      tb_sel_r   <= 1'b0;
      alert_en_r <= 1'b0;
      third_r    <= 1'b0;
      com_r      <= COMMONS_DEF;
      rate_r     <= RATE_DEF;
      test_r     <= 1'b0;
    end else begin
      src_r      <= src_nxt;
      osc_run_r  <= osc_run_nxt;
      bias_r     <= bias_nxt;
      tone_on_r  <= tone_on_nxt;
      tone_hi_r  <= tone_hi_nxt;
      tb_run_r   <= tb_run_nxt;
      tb_sel_r   <= tb_sel_nxt;
      alert_en_r <= alert_en_nxt;
      third_r    <= third_nxt;
      com_r      <= com_nxt;
      rate_r     <= rate_nxt;
      test_r     <= test_nxt;
    end
  end

  // ==========================================================
  // clock tree: source, prescaler, 32k divider, outputs
  logic [RC_CNT_W-1:0] rc_r, rc_nxt;
  logic [PRE_W-1:0]    pre_r, pre_nxt;
  logic [DIV_W-1:0]    div_r, div_nxt;
  logic rc_tick, sys_tick, tick32, tb_step, tb_level, wdt_flag;
  logic buz_p_nxt, buz_n_nxt, lcd_nxt, bias_o_nxt, al_n_nxt;

  always_comb begin
    // internal RC only approximated: integer divide of the system clock
    rc_tick  = (rc_r == RC_CNT_W'(RC_DIV - 1));
    rc_nxt   = rc_tick ? '0 : rc_r + 1'b1;
    sys_on   = osc_run_r || (src_r == SRC_EXT);
    sys_tick = sys_on && ((src_r == SRC_RC) ? rc_tick : osc_edge);
    pre_nxt  = pre_r;
    if (sys_tick && src_r != SRC_XTAL) begin
      pre_nxt = pre_r + 1'b1;
    end
    tick32  = sys_tick && (src_r == SRC_XTAL || pre_r == '1);
    div_nxt = div_r + DIV_W'(tick32);
    tb_step = tick32 && slsc_tb_gate(div_r, rate_r);
    lcd_nxt = tick32 && (div_r == LCD_DIV_END);
    buz_p_nxt = 1'b0;
    buz_n_nxt = 1'b0;
    if (sys_on && tone_on_r) begin
      buz_p_nxt = tone_hi_r ? div_r[TONE_HI_BIT] : div_r[TONE_LO_BIT];
      buz_n_nxt = !buz_p_nxt;
    end
    bias_o_nxt = bias_r && sys_on;
    al_n_nxt   = tb_sel_r ? tb_level : !wdt_flag;
  end

  slsc_timebase u_tb (
    .sys_clk_in   (sys_clk_in),
    .resetn_in    (resetn_in),
    .step_in      (tb_step),
    .run_in       (tb_run_r && sys_on),
    .clr_tb_in    (clr_tb),
    .watchdog_clear_cmd_in   (watchdog_clear_cmd),
    .tb_level_out (tb_level),
    .wdt_flag_out (wdt_flag)
  );

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rc_r           <= '0;
      pre_r          <= '0;
      div_r          <= '0;
      buzzer_pos_out <= 1'b0;
      buzzer_neg_out <= 1'b0;
      lcd_clk_out    <= 1'b0;
      bias_on_out    <= 1'b0;
      alert_n_out    <= 1'b1;
      alert_oe_out   <= 1'b0;
    end else begin
      rc_r           <= rc_nxt;
      pre_r          <= pre_nxt;
      div_r          <= div_nxt;
      buzzer_pos_out <= buz_p_nxt;
      buzzer_neg_out <= buz_n_nxt;
      lcd_clk_out    <= lcd_nxt;
      bias_on_out    <= bias_o_nxt;
      alert_n_out    <= al_n_nxt;
      alert_oe_out   <= alert_en_r;
    end
  end

  assign data_out       = dout_r;
  assign data_oe_out    = doe_r;
  assign bias_third_out = third_r;
  assign commons_out    = com_r;
  assign test_mode_out  = test_r;

  // ==========================================================
  // checks
  sequence s_word_in;
    wr_rise && !cs_hi && st_r == ST_DATA && mode_r == ID_WRITE &&
      wbit_r == 2'(WORD_W - 1);
  endsequence

  a_ram_word: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    s_word_in |=> ram_r[$past(ram_a)] == $past(wdata) &&
      addr_r == $past(addr_r) + 1'b1)
    else $error("word not stored or address not advanced");
  a_cs_reset: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) cs_hi |=> st_r == ST_ID && !data_oe_out)
    else $error("chip select did not reset interface");
  a_cmd_id: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (wr_rise && !cs_hi && st_r == ST_ID && cnt_r == 4'(ID_W - 1) &&
      cmd[ID_W-1:0] == ID_CMD) |=> st_r == ST_CMD)
    else $error("command ID not recognised");
  a_ext_halt: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (cmd_go && cmd[8:1] == {GRP_SYS, OP_HALT} && src_r == SRC_EXT) |=>
      (osc_run_r == $past(osc_run_r) && sys_on))
    else $error("external source entered power-down");
  a_buzz_quiet: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (!sys_on || !tone_on_r) |=> !buzzer_pos_out && !buzzer_neg_out)
    else $error("buzzer driven while off");
  a_alert_float: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) !alert_en_r [*2] |-> !alert_oe_out)
    else $error("alert driven while disabled");
  a_wdt_hold: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (wdt_flag && !tb_sel_r && alert_en_r) |=>
      (!alert_n_out && alert_oe_out))
    else $error("timeout did not hold alert low");
  a_prescale: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in)
    (tick32 && src_r != SRC_XTAL) |-> pre_r == '1)
    else $error("256k source not prescaled");
  a_blank: assert property (@(posedge sys_clk_in)
    disable iff (!resetn_in) !sys_on |=> !bias_on_out)
    else $error("bias on while halted");
endmodule : slsc_top

// ### verification/slsc_host_model.sv
`timescale 1ns/100ps
module slsc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic data_line_in,
  output logic      cs_n_out,
  output logic      wr_n_out,
  output logic      rd_n_out,
  output logic      data_out,
  output logic      data_oe_out
);
  // ==========================================================
  // idle: deselected, strobes high, data pin released
  initial begin
    cs_n_out    = 1'b1;
    wr_n_out    = 1'b1;
    rd_n_out    = 1'b1;
    data_out    = 1'b1;
    data_oe_out = 1'b0;
  end

  task automatic select(input logic deselect);
    @(posedge sys_clk_in);
    cs_n_out <= deselect;
    repeat (8) @(posedge sys_clk_in);
  endtask : select

  // 8-clock strobe phases stay clear of the 2-clock filter minimum
  task automatic wbit(input logic b);
    @(posedge sys_clk_in);
    data_out    <= b;
    data_oe_out <= 1'b1;
    wr_n_out    <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    wr_n_out <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
  endtask : wbit

  // sample late in the high phase, long after the answer settled
  task automatic rbit(output logic b);
    @(posedge sys_clk_in);
    data_oe_out <= 1'b0;
    rd_n_out    <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rd_n_out <= 1'b1;
    repeat (7) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    b = data_line_in;
  endtask : rbit
endmodule : slsc_host_model

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import slsc_pkg::*;
  logic sys_clk_in, resetn_in, cs_n, wr_n, rd_n, host_d, host_oe;
  logic data_line, dev_d, dev_oe, alert_n, alert_oe, bz_p, bz_n;
  logic bias_on, bias_third, lcd_clk, test_mode;
  logic [1:0] commons;
  logic [RAM_WORDS*WORD_W-1:0] seg_ram;
  logic [3:0] rw;
  logic [2:0] osc_div;
  logic       t0;
  int mismatches, cmp_count, cycles, lcd_cnt, n0;

  // pull-up holds the data pin high while nobody drives it
  assign data_line = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);

  slsc_top i_slsc_top (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .data_in(data_line),
    .osc_input_pin_in(osc_div[2]), .data_out(dev_d), .data_oe_out(dev_oe),
    .alert_n_out(alert_n), .alert_oe_out(alert_oe),
    .buzzer_pos_out(bz_p), .buzzer_neg_out(bz_n), .bias_on_out(bias_on),
    .bias_third_out(bias_third), .commons_out(commons),
    .lcd_clk_out(lcd_clk), .test_mode_out(test_mode),
    .seg_ram_out(seg_ram));

  slsc_host_model i_slsc_host_model (.sys_clk_in(sys_clk_in),
    .data_line_in(data_line), .cs_n_out(cs_n), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .data_out(host_d), .data_oe_out(host_oe));

  // ==========================================================
  // clock and watchdog on the run
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // crystal or external clock pin: eight system clocks a period keep each
  // level well past the pin filter; low through reset, as its idle level
  always @(posedge sys_clk_in) begin
    osc_div <= resetn_in ? osc_div + 3'h1 : 3'h0;
    if (lcd_clk === 1'b1) begin
      lcd_cnt <= lcd_cnt + 1;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic id3(input logic [2:0] v);
    for (int i = 2; i >= 0; i--) i_slsc_host_model.wbit(v[i]);
  endtask : id3

  task automatic cmd9(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) i_slsc_host_model.wbit(v[i]);
  endtask : cmd9

  task automatic addr6(input logic [5:0] v);
    for (int i = 5; i >= 0; i--) i_slsc_host_model.wbit(v[i]);
  endtask : addr6

  // data words travel low bit first
  task automatic word_w(input logic [3:0] v);
    for (int i = 0; i < 4; i++) i_slsc_host_model.wbit(v[i]);
  endtask : word_w

  task automatic word_r(output logic [3:0] v);
    for (int i = 0; i < 4; i++) i_slsc_host_model.rbit(v[i]);
  endtask : word_r

  // ==========================================================
  // main sequence
  initial begin
    resetn_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    chk("defaults", {bias_on, alert_oe, bz_p, bz_n, bias_third, commons,
        test_mode, alert_n}, 32'h1);
    // a partial mode ID must be forgotten at deselect
    i_slsc_host_model.select(1'b0);
    i_slsc_host_model.wbit(1'b1);
    i_slsc_host_model.wbit(1'b1);
    i_slsc_host_model.select(1'b1);
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h002);
    cmd9(9'h006);
    cmd9(9'h052);
    i_slsc_host_model.select(1'b1);
    chk("bias_on", bias_on, 32'h1);
    chk("panel_bias_commons_cmd", {bias_third, commons}, 32'h6);
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h048);
    cmd9(9'h012);
    cmd9(9'h110);
    i_slsc_host_model.select(1'b1);
    chk("panel_bias_commons_cmd", {bias_third, commons}, 32'h1);
    chk("buzzer_diff", bz_p ^ bz_n, 32'h1);
    chk("alert_oe", alert_oe, 32'h1);
    i_slsc_host_model.select(1'b0);
    id3(ID_WRITE);
    addr6(6'h05);
    word_w(4'ha);
    word_w(4'h3);
    i_slsc_host_model.select(1'b1);
    chk("ram5", seg_ram[23:20], 32'ha);
    chk("ram6", seg_ram[27:24], 32'h3);
    i_slsc_host_model.select(1'b0);
    id3(ID_READ);
    addr6(6'h05);
    word_r(rw);
    chk("read5", rw, 32'ha);
    word_r(rw);
    chk("read6", rw, 32'h3);
    i_slsc_host_model.select(1'b1);
    // read-modify-write: show word 6, then overwrite it
    i_slsc_host_model.select(1'b0);
    id3(ID_WRITE);
    addr6(6'h06);
    word_r(rw);
    chk("rmw_read", rw, 32'h3);
    word_w(4'h9);
    i_slsc_host_model.select(1'b1);
    chk("rmw_write", seg_ram[27:24], 32'h9);
    // crystal source, watchdog cleared before it is armed
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h028);
    cmd9(9'h01c);
    cmd9(9'h00e);
    i_slsc_host_model.select(1'b1);
    chk("alert_idle", alert_n, 32'h1);
    n0 = lcd_cnt;
    repeat (4096) @(posedge sys_clk_in);
    chk("lcd_rate", lcd_cnt - n0, 32'h4);
    repeat (4904) @(posedge sys_clk_in);
    chk("alert_timeout", {alert_oe, alert_n}, 32'h2);
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h01c);
    i_slsc_host_model.select(1'b1);
    chk("alert_clear", alert_n, 32'h1);
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h018);
    cmd9(9'h00c);
    cmd9(9'h1c0);
    i_slsc_host_model.select(1'b1);
    chk("test_mode", test_mode, 32'h1);
    t0 = alert_n;
    repeat (1024) @(posedge sys_clk_in);
    chk("tick_out", alert_n, !t0);
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h000);
    cmd9(9'h100);
    cmd9(9'h1c6);
    i_slsc_host_model.select(1'b1);
    chk("buzzers", {bz_p, bz_n}, 32'h0);
    chk("bias_halt", bias_on, 32'h0);
    chk("alert_off", alert_oe, 32'h0);
    chk("normal", test_mode, 32'h0);
    // external source: halt is ignored, panel and tone keep running
    i_slsc_host_model.select(1'b0);
    id3(ID_CMD);
    cmd9(9'h038);
    cmd9(9'h006);
    cmd9(9'h000);
    i_slsc_host_model.select(1'b1);
    chk("ext_run", {bias_on, bz_p ^ bz_n}, 32'h3);
    report_and_stop();
  end
endmodule : testbench
